// ==== hw/llcg_pkg.sv ====
package llcg_pkg;
	// ------------------------------------------------------------
	// clocking
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 100;
	localparam int REF_MULT = 4;
	localparam int HALF_DIV = 2;
	// ------------------------------------------------------------
	// reset sequencing
	// ------------------------------------------------------------
	localparam int RESET_HOLD_MS = 20;
	localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * 1000 * SYS_CLK_MHZ;
	localparam int CNT_W = 32;
	localparam int REF_MEAS_W = 8;
	localparam int PH_W = 16;
	localparam logic [PH_W-1:0] PH_STEP_RESET = 16'h0b33;

	typedef enum logic [1:0] {
		LLCG_POR_HOLD = 2'b00,
		LLCG_POR_WAIT_REF = 2'b01,
		LLCG_POR_RUN = 2'b11
	} llcg_por_t;

	typedef struct packed {
		logic x4;
		logic x2;
		logic x2_aux;
	} llcg_clks_t;
endpackage

// ==== hw/llcg_top.sv ====
`timescale 1ns/10ps
// Functional notes
// - a reset sequence starts at power-up, on supply drop below threshold and on chip enable.
// - during a sequence the reset output is held low for the capacitor-set interval.
// - the reset output is active low and may reset the rest of the system.
// - with bypass select low the clocks are phase-locked to the reference.
// - clock output buffers are enabled while output enable is high.
// - with bypass select low the fast clock runs at four times the reference frequency.
// - with bypass select low both half-rate clocks run at twice the reference frequency.
// - with output enable low all clocks are forced high and reset is held low.
// - with bypass select high the reference drives the oscillator stage directly.
// - half-rate clocks come from the fast clock divided by two, square.
module llcg_top
	import llcg_pkg::*;
#(
	parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic LINE_REF_IN,
	input wire logic PLL_BYPASS_SELECT,
	input wire logic CHIP_ENABLE,
	input wire logic SUPPLY_LOW,
	output logic CLK_X4_OUT,
	output logic CLK_X2_OUT,
	output logic CLK_X2_AUX_OUT,
	output logic SYSTEM_RESET_OUT_N
);
	// ------------------------------------------------------------
	// local constants
	// ------------------------------------------------------------
	// toggles of the fast clock between two forced rises at the ref edge
	localparam int X4_TOGGLES = REF_MULT * HALF_DIV - 1;
	// shorter spans mean a ref far out of range; clamp keeps step in width
	localparam int MIN_SPAN = 10;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// one rising-edge test shared by every rising-edge detector
	function automatic logic rise_of(input logic now, input logic was);
		return now & ~was;
	endfunction

	// rounded up so the toggle budget is reached even on a period
	// one cycle shorter than the last one measured
	function automatic logic [PH_W-1:0] step_for(input logic [REF_MEAS_W-1:0] span);
		logic [31:0] den;
		logic [31:0] num;
		if (span >= REF_MEAS_W'(MIN_SPAN))
			den = 32'(span) - 32'd2;
		else
			den = 32'(MIN_SPAN - 2);
		num = 32'(X4_TOGGLES) << PH_W;
		return PH_W'((num + den - 32'd1) / den);
	endfunction

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [1:0] ref_s;
	logic [1:0] byp_s;
	logic [1:0] ce_s;
	logic [1:0] low_s;
	logic ref_d;
	always_ff @(posedge SYS_CLK) begin
		ref_s <= {ref_s[0], LINE_REF_IN};
		byp_s <= {byp_s[0], PLL_BYPASS_SELECT};
		ce_s <= {ce_s[0], CHIP_ENABLE};
		low_s <= {low_s[0], SUPPLY_LOW};
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ref_d <= 1'b0;
		end else begin
			ref_d <= ref_s[1];
		end
	end

	wire ref_rise = rise_of(ref_s[1], ref_d);
	wire ref_edge = ref_s[1] ^ ref_d;
	wire ce = ce_s[1];
	wire bypass = byp_s[1];
	wire supply_low = low_s[1];

	// ------------------------------------------------------------
	// power-on reset sequencer
	// ------------------------------------------------------------
	llcg_por_t por;
	llcg_por_t next_por;
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] next_hold_cnt;
	logic ce_d;
	wire ce_rise = rise_of(ce, ce_d);
	// power-up itself is RST; the pin stands in for the supply detector
	wire restart = supply_low | ce_rise;
	wire hold_done = (hold_cnt >= CNT_W'(HOLD_CYCLES - 1));
	wire in_hold = (por == LLCG_POR_HOLD);

	always_comb begin
		next_por = por;
		case (por)
			LLCG_POR_HOLD: begin
				if (hold_done)
					next_por = LLCG_POR_WAIT_REF;
			end
			LLCG_POR_WAIT_REF: begin
				// release waits for a live reference edge
				if (ref_rise)
					next_por = LLCG_POR_RUN;
			end
			LLCG_POR_RUN: begin
				next_por = LLCG_POR_RUN;
			end
			default: begin
				next_por = LLCG_POR_HOLD;
			end
		endcase
		if (restart)
			next_por = LLCG_POR_HOLD;
	end

	assign next_hold_cnt = (restart || !in_hold) ? '0 : hold_cnt + 1'b1;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			por <= LLCG_POR_HOLD;
			hold_cnt <= '0;
			ce_d <= 1'b0;
		end else begin
			por <= next_por;
			hold_cnt <= next_hold_cnt;
			ce_d <= ce;
		end
	end

	// ------------------------------------------------------------
	// reference period tracker and oscillator
	// ------------------------------------------------------------
	// behavioural lock: measure ref period, step a phase accumulator so it
	// wraps often enough per ref period; coarse jitter is the trade-off
	logic [REF_MEAS_W-1:0] per_cnt;
	logic [REF_MEAS_W-1:0] next_per_cnt;
	logic [PH_W-1:0] ph_step;
	logic [PH_W-1:0] phase;
	logic [2:0] tgl_cnt;
	logic x4;
	logic x4_d;
	logic x2;
	wire [PH_W:0] ph_sum = {1'b0, phase} + {1'b0, ph_step};
	wire [PH_W-1:0] meas_step = step_for(per_cnt);
	// a missing ref must not wrap the period count into a tiny span
	wire per_full = (per_cnt == '1);
	// capped toggles make the forced rise at the ref edge always the first
	// of four, whatever the one-cycle jitter of the synchronised ref
	wire budget_left = (tgl_cnt < 3'(X4_TOGGLES));
	wire wrap = ph_sum[PH_W] & budget_left;
	wire x4_tgl = rise_of(x4, x4_d);

	assign next_per_cnt = ref_rise ? REF_MEAS_W'(1) : (per_full ? per_cnt : per_cnt + 1'b1);

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			per_cnt <= '0;
			ph_step <= PH_STEP_RESET;
		end else begin
			per_cnt <= next_per_cnt;
			if (ref_rise && !bypass)
				ph_step <= meas_step;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			phase <= '0;
			tgl_cnt <= '0;
			x4 <= 1'b0;
		end else if (bypass) begin
			// reference drives the oscillator stage directly
			phase <= '0;
			tgl_cnt <= '0;
			if (ref_edge)
				x4 <= ref_s[1];
		end else if (ref_rise) begin
			phase <= '0;
			tgl_cnt <= '0;
			x4 <= 1'b1;
		end else begin
			phase <= ph_sum[PH_W-1:0];
			if (wrap) begin
				tgl_cnt <= tgl_cnt + 1'b1;
				x4 <= ~x4;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			x4_d <= 1'b0;
			x2 <= 1'b0;
		end else begin
			x4_d <= x4;
			// single divide-by-two stage feeds both half-rate outputs
			if (x4_tgl)
				x2 <= ~x2;
		end
	end

	// ------------------------------------------------------------
	// output buffers
	// ------------------------------------------------------------
	llcg_clks_t next_clks;
	logic next_reset_n;
	wire en = ce & ~RST;

	always_comb begin
		next_clks.x4 = en ? x4 : 1'b1;
		next_clks.x2 = en ? x2 : 1'b1;
		next_clks.x2_aux = en ? x2 : 1'b1;
	end

	assign next_reset_n = ce && next_por == LLCG_POR_RUN;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CLK_X4_OUT <= 1'b1;
			CLK_X2_OUT <= 1'b1;
			CLK_X2_AUX_OUT <= 1'b1;
			SYSTEM_RESET_OUT_N <= 1'b0;
		end else begin
			CLK_X4_OUT <= next_clks.x4;
			CLK_X2_OUT <= next_clks.x2;
			CLK_X2_AUX_OUT <= next_clks.x2_aux;
			SYSTEM_RESET_OUT_N <= next_reset_n;
		end
	end
endmodule

// ==== tb/llcg_ref_src.sv ====
`timescale 1ns/10ps
module llcg_ref_src (
	input int half_ns,
	output logic ref_out);
	// a decoder reference runs free, so it is never parked
	// fractional offset keeps its edges off the system clock edges
	initial begin
		ref_out = 1'b0;
		#0.3;
		forever #(half_ns) ref_out = ~ref_out;
	end
endmodule

// ==== tb/llcg_top_sva.sv ====
`timescale 1ns/10ps
module llcg_top_sva #(parameter int HOLD_CYCLES = 50) (
	input logic SYS_CLK, RST, LINE_REF_IN, PLL_BYPASS_SELECT, CHIP_ENABLE, SUPPLY_LOW,
	input logic CLK_X4_OUT, CLK_X2_OUT, CLK_X2_AUX_OUT, SYSTEM_RESET_OUT_N);
	int lo;
	wire run = CHIP_ENABLE && SYSTEM_RESET_OUT_N;
	always_ff @(posedge SYS_CLK) lo <= SYSTEM_RESET_OUT_N ? 0 : lo + 1;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	chk_aux_same: assert property (CLK_X2_OUT == CLK_X2_AUX_OUT) else $error("aux");
	chk_off_clk: assert property ((!CHIP_ENABLE)[*4] |-> CLK_X4_OUT && CLK_X2_OUT)
		else $error("park");
	chk_off_rst: assert property ((!CHIP_ENABLE)[*4] |-> !SYSTEM_RESET_OUT_N)
		else $error("hold");
	chk_x2_step: assert property (run && $rose(CLK_X4_OUT) |=> $changed(CLK_X2_OUT))
		else $error("step");
	chk_hold_min: assert property ($rose(SYSTEM_RESET_OUT_N) |-> $past(lo) >= HOLD_CYCLES)
		else $error("short");
	chk_drop_rst: assert property ($rose(SUPPLY_LOW) |-> ##[1:4] !SYSTEM_RESET_OUT_N)
		else $error("drop");
	chk_ce_restart: assert property ($rose(CHIP_ENABLE) |=> (!SYSTEM_RESET_OUT_N)[*8])
		else $error("restart");
	chk_byp_follow: assert property (run && PLL_BYPASS_SELECT && $past(PLL_BYPASS_SELECT, 4)
		&& $rose(CLK_X4_OUT) |-> $past(LINE_REF_IN, 2)) else $error("bypass");
	cover property ($rose(SYSTEM_RESET_OUT_N));
	cover property (PLL_BYPASS_SELECT && $rose(CLK_X2_OUT));
	cover property ($rose(SUPPLY_LOW));
endmodule
bind llcg_top llcg_top_sva #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);

// ==== tb/test_llcg_top.sv ====
`timescale 1ns/10ps
module test_llcg_top import llcg_pkg::*; ;
	localparam int HOLD = 50;
	logic clk = 0, rst = 1, byp = 0, ce = 1, sup = 0, rn, ref_in, p, q;
	wire llcg_clks_t ck;
	int mismatches = 0, check_count = 0, t, c, c2, d;
	llcg_ref_src src (.half_ns(71), .ref_out(ref_in));
	llcg_top #(.HOLD_CYCLES(HOLD)) dut (.SYS_CLK(clk), .RST(rst), .LINE_REF_IN(ref_in),
		.PLL_BYPASS_SELECT(byp), .CHIP_ENABLE(ce), .SUPPLY_LOW(sup), .CLK_X4_OUT(ck.x4),
		.CLK_X2_OUT(ck.x2), .CLK_X2_AUX_OUT(ck.x2_aux), .SYSTEM_RESET_OUT_N(rn));
	initial forever #5 clk = ~clk;
	task check(logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %0d", $time, got);
		end
	endtask
	task report_and_stop;
		$display("%0d checks %0d mismatches", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task rel;
		for (t = 0; rn !== 1'b1 && t < 999; t++) @(posedge clk);
		check(t > HOLD - 9 && t < HOLD + 40, 1);
	endtask
	// twenty reference periods; loop quantises to 10 ns, hence the slack
	task rate(logic b, int e);
		byp <= b;
		repeat (40) @(posedge clk);
		c = 0;
		c2 = 0;
		d = 0;
		p = ck.x4;
		q = ck.x2;
		repeat (284) begin
			@(posedge clk);
			c += int'(ck.x4 & ~p);
			c2 += int'(ck.x2 & ~q);
			d += int'(ck.x2 !== ck.x2_aux);
			p = ck.x4;
			q = ck.x2;
		end
		check(c > e - 4 && c < e + 4, 1);
		check(c2 > e / 2 - 3 && c2 < e / 2 + 3, 1);
		check(d, 0);
		$display("rate end");
	endtask
	task restart(logic off);
		{ce, sup} <= {2{~off}};
		repeat (6) @(posedge clk);
		check(rn, 0);
		if (off) check(ck, 7);
		{ce, sup} <= 2'b10;
		rel;
		$display("restart end");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		rel;
		rate(0, 80);
		rate(1, 20);
		restart(1);
		restart(0);
		report_and_stop;
	end
	initial begin
		#100000;
		mismatches++;
		report_and_stop;
	end
endmodule
